// >>> psrm_delay.sv
module psrm_delay
   import psrm_pkg::*;
#(
   parameter int DELAY = DELAY_CYCLES
) (
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic clockEnable,
   input  wire logic start,
   output logic      done
);
   logic [CNT_W-1:0] count;

   // count restarts whenever the qualifying input drops before expiry
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         count <= '0;
         done  <= 1'b0;
      end else if (clockEnable) begin
         if (!start) begin
            count <= '0;
            done  <= 1'b0;
         end else if (count >= CNT_W'(DELAY - 1)) begin
            done  <= 1'b1;
         end else begin
            count <= count + CNT_W'(1);
         end
      end
   end
endmodule // psrm_delay

// >>> psrm_host_model.sv
module psrm_host_model
   import psrm_pkg::*;
(
   input  wire logic [1:0] mode,
   input  wire logic [3:0] randReq,
   input  wire logic [1:0] voltFault,
   input  wire logic       overCurrent,
   input  wire logic       gateEnable,
   input  wire logic       supply_good_n,
   input  wire logic [3:0] rail_ok_n,
   output psrm_sense_s     sense,
   output logic [3:0]      rail_request_n
);
   // fet reads on the very cycle the gate moves: harshest case
   assign sense = {voltFault, overCurrent, gateEnable, gateEnable};
   always_comb begin
      case (mode)
         2'h1: rail_request_n = {4{supply_good_n}};
         2'h2: rail_request_n = {rail_ok_n[2:0], supply_good_n};
         default: rail_request_n = randReq;
      endcase
   end
endmodule // psrm_host_model

// >>> psrm_pkg.sv
package psrm_pkg;
   localparam int  CLK_HZ         = 20_000_000;
   localparam int  DELAY_MS       = 100;
   localparam int  DELAY_CYCLES   = (CLK_HZ / 1000) * DELAY_MS;
   localparam int  RETRY_MS       = 100;
   localparam int  RETRY_CYCLES   = (CLK_HZ / 1000) * RETRY_MS;
   localparam int  RETRY_LIMIT    = 5;
   localparam int  RAIL_COUNT     = 4;
   localparam int  CNT_W          = 32;
   localparam logic RESET_ACTIVE  = 1'b0;

   typedef enum logic [1:0] {
      PSRM_GATE_ON    = 2'b00,
      PSRM_GATE_WAIT  = 2'b01,
      PSRM_GATE_DEAD  = 2'b10
   } psrm_gate_e;

   typedef struct packed {
      logic overVoltage;
      logic underVoltage;
      logic overCurrent;
      logic drainOn;
      logic gateOn;
   } psrm_sense_s;
endpackage

// >>> psrm_seq_chk.sv
module psrm_seq_chk
   import psrm_pkg::*;
#(parameter int DELAY = 20) (
   input wire logic        clock,
   input wire logic        sys_rst,
   input wire logic        clockEnable,
   input wire psrm_sense_s sense,
   input wire logic [3:0]  rail_request_n,
   input wire logic        hot_side_manual_clear_n,
   input wire logic        cold_side_manual_restart,
   input wire logic        gateEnable,
   input wire logic        supply_good_n,
   input wire logic [3:0]  rail_ok_n,
   input wire logic        systemReset,
   input wire logic        retry_exhausted_flag
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   int reqCnt, allCnt;
   // run lengths; counters stand in for repetitions far too long to unroll
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         reqCnt <= 0;
         allCnt <= 0;
      end else if (clockEnable) begin
         reqCnt <= rail_request_n[0] ? 0 : reqCnt + 1;
         allCnt <= (!supply_good_n && rail_ok_n == 4'h0) ? allCnt + 1 : 0;
      end
   end
   AST_COLD: assert property (cold_side_manual_restart |=> supply_good_n)
      else $error("cold override");
   AST_HOTGATE: assert property (!hot_side_manual_clear_n |=> !gateEnable)
      else $error("gate override");
   AST_HOTFLAG: assert property (!hot_side_manual_clear_n |=> !retry_exhausted_flag)
      else $error("flag clear");
   AST_RAILUP: assert property ((~rail_ok_n & $past(rail_request_n)) == 4'h0)
      else $error("rail ok early");
   AST_RAIL0: assert property (rail_ok_n[0] == (reqCnt <= DELAY))
      else $error("rail delay");
   AST_RST: assert property (!systemReset |-> allCnt >= DELAY)
      else $error("reset release");
   AST_PGOOD: assert property (!supply_good_n |-> $past(sense) == 5'h03)
      else $error("supply good");
   AST_FLAGGATE: assert property (retry_exhausted_flag |=> !gateEnable)
      else $error("gate after give up");
   AST_FREEZE: assert property (!clockEnable |=> $stable({gateEnable, supply_good_n, rail_ok_n, systemReset, retry_exhausted_flag}))
      else $error("state moved while frozen");
   cover property (!systemReset);
   cover property (retry_exhausted_flag);
   cover property (cold_side_manual_restart ##1 supply_good_n);
endmodule // psrm_seq_chk
bind psrm_sequencer psrm_seq_chk #(.DELAY(DELAY)) psrm_seq_chk_i (.*);

// >>> psrm_sequencer.sv
module psrm_sequencer
   import psrm_pkg::*;
#(
   parameter int DELAY       = DELAY_CYCLES,
   parameter int RETRY_DELAY = RETRY_CYCLES,
   parameter bit LIMITED     = 1'b1
) (
   input  wire logic                  clock,
   input  wire logic                  sys_rst,
   input  wire logic                  clockEnable,
   input  wire psrm_sense_s           sense,
   input  wire logic [RAIL_COUNT-1:0] rail_request_n,
   input  wire logic                  hot_side_manual_clear_n,
   input  wire logic                  cold_side_manual_restart,
   output logic                       gateEnable,
   output logic                       supply_good_n,
   output logic [RAIL_COUNT-1:0]      rail_ok_n,
   output logic                       systemReset,
   output logic                       retry_exhausted_flag
);
   logic [RAIL_COUNT-1:0] railDone;
   logic                  resetDone;
   logic                  allGood;
   logic                  noFault;
   logic                  retryDone;
   logic                  fetOn;
   logic                  giveUp;
   logic [2:0]            failCount;
   psrm_gate_e            gateState;

   genvar i;
   generate
      for (i = 0; i < RAIL_COUNT; i++) begin : g_rail
         psrm_delay #(.DELAY(DELAY)) u_delay (
            .clock       (clock),
            .sys_rst     (sys_rst),
            .clockEnable (clockEnable),
            .start       (!rail_request_n[i]),
            .done        (railDone[i])
         );
         always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               rail_ok_n[i] <= 1'b1;
            end else if (clockEnable) begin
               // done falls a cycle after the request rises, so the request gates ok here
               rail_ok_n[i] <= !(railDone[i] && !rail_request_n[i]);
            end
         end
      end
   endgenerate

   assign allGood = !supply_good_n && (rail_ok_n == '0);

   psrm_delay #(.DELAY(DELAY)) u_reset_delay (
      .clock       (clock),
      .sys_rst     (sys_rst),
      .clockEnable (clockEnable),
      .start       (allGood),
      .done        (resetDone)
   );

   // reset output is active high here; active from power-up
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         systemReset <= 1'b1;
      end else if (clockEnable) begin
         systemReset <= !(resetDone && allGood);
      end
   end

   assign noFault = !sense.overVoltage && !sense.underVoltage && !sense.overCurrent;

   // retry timer only runs in the wait state
   psrm_delay #(.DELAY(RETRY_DELAY)) u_retry_delay (
      .clock       (clock),
      .sys_rst     (sys_rst),
      .clockEnable (clockEnable),
      .start       (gateState == PSRM_GATE_WAIT),
      .done        (retryDone)
   );

   assign fetOn = noFault && sense.drainOn && sense.gateOn;

   // five retries must actually run and fail before giving up
   assign giveUp = LIMITED && (failCount >= 3'(RETRY_LIMIT));

   // soft reinsert: a hot-side clear always lands back in the on state
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         gateState <= PSRM_GATE_ON;
      end else if (clockEnable) begin
         if (!hot_side_manual_clear_n) begin
            gateState <= PSRM_GATE_ON;
         end else begin
            case (gateState)
               PSRM_GATE_ON: begin
                  if (sense.overCurrent && giveUp) begin
                     gateState <= PSRM_GATE_DEAD;
                  end else if (sense.overCurrent) begin
                     gateState <= PSRM_GATE_WAIT;
                  end
               end
               PSRM_GATE_WAIT: begin
                  if (retryDone) begin
                     gateState <= PSRM_GATE_ON;
                  end
               end
               PSRM_GATE_DEAD: gateState <= PSRM_GATE_DEAD;
               default:        gateState <= PSRM_GATE_ON;
            endcase
         end
      end
   end

   // retries that ran; saturates so the unlimited variant cannot wrap
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         failCount <= '0;
      end else if (clockEnable) begin
         if (!hot_side_manual_clear_n) begin
            failCount <= '0;
         end else if (gateState == PSRM_GATE_ON && fetOn) begin
            failCount <= '0;
         end else if (gateState == PSRM_GATE_WAIT && retryDone
                      && failCount < 3'(RETRY_LIMIT)) begin
            failCount <= failCount + 3'd1;
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         gateEnable <= 1'b0;
      end else if (clockEnable) begin
         gateEnable <= hot_side_manual_clear_n && noFault
                       && (gateState == PSRM_GATE_ON);
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         retry_exhausted_flag <= 1'b0;
      end else if (clockEnable) begin
         if (!hot_side_manual_clear_n) begin
            retry_exhausted_flag <= 1'b0;
         end else if (gateState == PSRM_GATE_DEAD) begin
            retry_exhausted_flag <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         supply_good_n <= 1'b1;
      end else if (clockEnable) begin
         if (cold_side_manual_restart) begin
            supply_good_n <= 1'b1;
         end else begin
            supply_good_n <= !(noFault && sense.drainOn && sense.gateOn
                               && gateEnable);
         end
      end
   end
endmodule // psrm_sequencer

// >>> psrm_sequencer_tb.sv
`define CHK(s, e, a) begin totalChecks++; if ((a) !== (e)) begin miscompares++; \
   $display("[ERR] %s exp %h got %h", s, e, a); end end
module psrm_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DLY = 20;
   logic clock = 0, sys_rst = 1, clockEnable = 1, overCurrent = 0;
   logic hot_side_manual_clear_n = 1, cold_side_manual_restart = 0;
   logic gateEnable, supply_good_n, systemReset, retry_exhausted_flag;
   logic [1:0] mode = 2'h0, voltFault = 2'h0;
   logic [3:0] randReq = 4'hf, rail_request_n, rail_ok_n, r;
   psrm_pkg::psrm_sense_s sense;
   int miscompares = 0, totalChecks = 0, cycles = 0, n;
   psrm_sequencer #(.DELAY(DLY), .RETRY_DELAY(DLY)) psrm_sequencer_i (.*);
   psrm_host_model psrm_host_model_i (.*);
   initial forever #25 clock = ~clock;
   task automatic report_and_stop;
      if (miscompares == 0 && totalChecks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         report_and_stop();
      end
   end
   task automatic cyc(input int k);
      repeat (k) @(negedge clock);
   endtask
   function automatic logic [3:0] expOk(input logic [3:0] req, input int k);
      return req | {4{k <= DLY}};
   endfunction
   initial begin
      void'($urandom(32'h15281e5a));
      cyc(12);
      sys_rst = 0;
      cyc(10);
      for (int i = 0; i < 30; i++) begin
         randReq = 4'hf;
         cyc(2);
         r = 4'($urandom);
         randReq = r;
         n = (i % 2) ? $urandom_range(DLY + 3, DLY) : $urandom_range(DLY + 3, 1);
         cyc(n);
         `CHK("railOk", expOk(r, n), rail_ok_n)
      end
      randReq = 4'hf;
      cyc(2);
      clockEnable = 0;
      randReq = 4'h0;
      cyc(DLY + 5);
      `CHK("frozen", 4'hf, rail_ok_n)
      clockEnable = 1;
      cyc(DLY + 1);
      `CHK("railOk", 4'h0, rail_ok_n)
      mode = 2'h1;
      cyc(3 * DLY + 20);
      `CHK("sysRst", 1'b0, systemReset)
      mode = 2'h2;
      cold_side_manual_restart = 1;
      cyc(110);
      `CHK("supplyGood", 1'b1, supply_good_n)
      cold_side_manual_restart = 0;
      cyc(6 * DLY + 40);
      `CHK("sysRst", 1'b0, systemReset)
      voltFault = 2'($urandom_range(3, 1));
      cyc(3);
      `CHK("gate", 1'b0, gateEnable)
      `CHK("supplyGood", 1'b1, supply_good_n)
      voltFault = 2'h0;
      cyc(3);
      `CHK("supplyGood", 1'b0, supply_good_n)
      hot_side_manual_clear_n = 0;
      cyc(110);
      `CHK("gate", 1'b0, gateEnable)
      hot_side_manual_clear_n = 1;
      cyc(5);
      `CHK("gate", 1'b1, gateEnable)
      overCurrent = 1;
      cyc(12 * DLY + 40);
      overCurrent = 0;
      cyc(3 * DLY);
      `CHK("flag", 1'b1, retry_exhausted_flag)
      hot_side_manual_clear_n = 0;
      cyc(110);
      `CHK("flag", 1'b0, retry_exhausted_flag)
      hot_side_manual_clear_n = 1;
      cyc(5);
      `CHK("gate", 1'b1, gateEnable)
      report_and_stop();
   end
endmodule // psrm_sequencer_tb
